// file: gpp_pkg.sv
// constants shared by the general-purpose port block
package gpp_pkg;

  // ********************************************************************
  // port geometry
  // ********************************************************************
  localparam int NUM_PORTS = 3;
  localparam int NUM_KINDS = 7;
  localparam int FIRST_WIDTH = 6;
  localparam int SECOND_WIDTH = 4;
  localparam int THIRD_WIDTH_DEF = 8;
  localparam int ADDR_W = 16;

  // ********************************************************************
  // stored register kinds, one row each in the register array
  // ********************************************************************
  localparam int K_LAT = 0;
  localparam int K_DIR = 1;
  localparam int K_ANA = 2;
  localparam int K_WPU = 3;
  localparam int K_ODS = 4;
  localparam int K_THR = 5;
  localparam int K_SLW = 6;

  // ********************************************************************
  // register indices; byte address is four times the index
  // ********************************************************************
  localparam logic [13:0] PIN_IDX [NUM_PORTS] = '{14'h000C, 14'h000D, 14'h000E};
  localparam logic [13:0] REG_IDX [NUM_KINDS][NUM_PORTS] = '{
    '{14'h0018, 14'h0019, 14'h001A},
    '{14'h0012, 14'h0013, 14'h0014},
    '{14'h1F38, 14'h1F39, 14'h1F3A},
    '{14'h1F3B, 14'h1F3C, 14'h1F3D},
    '{14'h1F3E, 14'h1F3F, 14'h1F40},
    '{14'h1F41, 14'h1F42, 14'h1F43},
    '{14'h1F44, 14'h1F45, 14'h1F46}};

  // ********************************************************************
  // reset values per kind: pins come up as analog inputs
  // ********************************************************************
  localparam logic [7:0] RESET_VAL [NUM_KINDS] = '{
    8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00};

  // ********************************************************************
  // bus answers
  // ********************************************************************
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [7:0] ALL_BITS = 8'hFF;

endpackage

// file: gpp_pin_cell.sv
// per-pin driver, input buffer and ownership logic for one port
module gpp_pin_cell #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // software settings
  input wire logic [WIDTH-1:0] latch,
  input wire logic [WIDTH-1:0] dir,
  input wire logic [WIDTH-1:0] ana_sel,
  input wire logic [WIDTH-1:0] od_sel,
  input wire logic [WIDTH-1:0] wpu_sel,
  input wire logic [WIDTH-1:0] thr_sel,
  input wire logic [WIDTH-1:0] slw_sel,
  // ownership from outside
  input wire logic [WIDTH-1:0] cfg_own,
  input wire logic [WIDTH-1:0] aout_en,
  input wire logic [WIDTH-1:0] periph_en,
  input wire logic [WIDTH-1:0] periph_data,
  // pad
  input wire logic [WIDTH-1:0] pad_in,
  output logic [WIDTH-1:0] pad_out,
  output logic [WIDTH-1:0] pad_oe,
  // digital view of the pins
  output logic [WIDTH-1:0] pin_level,
  output logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] ain_active,
  output logic [WIDTH-1:0] pullup_en,
  output logic [WIDTH-1:0] ttl_sel,
  output logic [WIDTH-1:0] slew_lim
);

  logic [WIDTH-1:0] blocked;
  logic [WIDTH-1:0] src;

  // ********************************************************************
  // ownership: config bits, then analog out, then analog in, then port
  // ********************************************************************
  assign blocked = dir | cfg_own | aout_en; // RQ1 RQ8 RQ10
  // analog select deliberately absent from blocked
  assign src = (periph_en & periph_data) | (~periph_en & latch); // RQ6 RQ7 RQ9
  // analog out or analog select turns the input buffer off
  assign pin_level = pad_in & ~ana_sel & ~aout_en; // RQ5 RQ13

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pad_oe <= '0;
      pad_out <= '0;
    end else begin
      // open drain only pulls low: enable drops for a high bit
      pad_oe <= ~blocked & (~od_sel | ~src); // RQ1 RQ15
      pad_out <= src & ~od_sel; // RQ15
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      din <= '0;
      ain_active <= '0;
    end else begin
      din <= pin_level; // RQ6
      ain_active <= ana_sel & ~cfg_own & ~aout_en; // RQ11 RQ10
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pullup_en <= '0;
      ttl_sel <= '0;
      slew_lim <= '0;
    end else begin
      pullup_en <= wpu_sel;
      ttl_sel <= thr_sel;
      slew_lim <= slw_sel;
    end
  end

  // ********************************************************************
  // checks
  // ********************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  drive_off_a: assert property ((pad_oe & $past(blocked)) == '0) // RQ1
    else $error("driver on for input, owned or analog-out pin");
  analog_buf_a: assert property ((pin_level & (ana_sel | aout_en)) == '0) // RQ5
    else $error("digital read not zero on analog pin");
  sink_only_a: assert property ((pad_out & $past(od_sel)) == '0) // RQ15
    else $error("open-drain pin driven high");
  latch_drive_a: assert property (
    ((pad_out ^ $past(latch)) & pad_oe & ~$past(periph_en) & ~$past(od_sel)) == '0) // RQ7
    else $error("driven level differs from latch");
  ana_drive_a: assert property (
    (~$past(blocked) & ~$past(od_sel) & $past(ana_sel) & ~pad_oe) == '0) // RQ9
    else $error("analog select stopped a digital output");
  ain_gate_a: assert property ((ain_active & ~$past(ana_sel)) == '0) // RQ11
    else $error("analog input active outside analog mode");

endmodule

// file: gpp_port.sv
// general-purpose port block with register access over axi4-lite
//
// Summary of operation
// RQ1 - A direction bit of one turns the pin driver off, zero drives the output latch.
// RQ2 - Reading the pin-level register gives pin levels, reading the latch gives latch contents.
// RQ3 - Writes through the pin-level or latch register both land in the output latch.
// RQ4 - A pin-level write samples the pins, merges the written bits and stores it in the latch.
// RQ5 - A set analog-select bit turns off that pin's digital input buffer.
// RQ6 - A pin owned by a peripheral is not driven from the latch but stays readable.
// RQ7 - After reset every pin's output source is the port latch.
// RQ8 - An enabled analog output overrides digital output and releases the driver.
// RQ9 - Analog mode does not stop a digital output from driving the pin.
// RQ10 - Ownership order is config bits, analog out, analog in, then port and routed functions.
// RQ11 - Analog input functions are active only while the analog-select bit is set.
// RQ12 - The ports are 6, 4 (optional) and 6 or 8 bits wide, all bidirectional.
// RQ13 - A pin in analog input mode reads as zero on a digital read.
// RQ14 - All analog-select bits come out of reset set.
// RQ15 - Open-drain select makes the pin sink only, otherwise it drives both ways.
module gpp_port #(
  parameter bit SECOND_PRESENT = 1'b1,
  parameter int THIRD_WIDTH = gpp_pkg::THIRD_WIDTH_DEF
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // axi4-lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [gpp_pkg::ADDR_W-1:0] s_axi_awaddr,
  // axi4-lite write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // axi4-lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // axi4-lite read address
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [gpp_pkg::ADDR_W-1:0] s_axi_araddr,
  // axi4-lite read data
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // first port
  input wire logic [gpp_pkg::FIRST_WIDTH-1:0] first_pad_in,
  output logic [gpp_pkg::FIRST_WIDTH-1:0] first_pad_out,
  output logic [gpp_pkg::FIRST_WIDTH-1:0] first_pad_oe,
  input wire logic [gpp_pkg::FIRST_WIDTH-1:0] first_cfg_own,
  input wire logic [gpp_pkg::FIRST_WIDTH-1:0] first_aout_en,
  input wire logic [gpp_pkg::FIRST_WIDTH-1:0] first_periph_en,
  input wire logic [gpp_pkg::FIRST_WIDTH-1:0] first_periph_data,
  output logic [gpp_pkg::FIRST_WIDTH-1:0] first_din,
  output logic [gpp_pkg::FIRST_WIDTH-1:0] first_ain_active,
  output logic [gpp_pkg::FIRST_WIDTH-1:0] first_pullup_en,
  output logic [gpp_pkg::FIRST_WIDTH-1:0] first_ttl_sel,
  output logic [gpp_pkg::FIRST_WIDTH-1:0] first_slew_lim,
  // second port
  input wire logic [gpp_pkg::SECOND_WIDTH-1:0] second_pad_in,
  output logic [gpp_pkg::SECOND_WIDTH-1:0] second_pad_out,
  output logic [gpp_pkg::SECOND_WIDTH-1:0] second_pad_oe,
  input wire logic [gpp_pkg::SECOND_WIDTH-1:0] second_cfg_own,
  input wire logic [gpp_pkg::SECOND_WIDTH-1:0] second_aout_en,
  input wire logic [gpp_pkg::SECOND_WIDTH-1:0] second_periph_en,
  input wire logic [gpp_pkg::SECOND_WIDTH-1:0] second_periph_data,
  output logic [gpp_pkg::SECOND_WIDTH-1:0] second_din,
  output logic [gpp_pkg::SECOND_WIDTH-1:0] second_ain_active,
  output logic [gpp_pkg::SECOND_WIDTH-1:0] second_pullup_en,
  output logic [gpp_pkg::SECOND_WIDTH-1:0] second_ttl_sel,
  output logic [gpp_pkg::SECOND_WIDTH-1:0] second_slew_lim,
  // third port
  input wire logic [THIRD_WIDTH-1:0] third_pad_in,
  output logic [THIRD_WIDTH-1:0] third_pad_out,
  output logic [THIRD_WIDTH-1:0] third_pad_oe,
  input wire logic [THIRD_WIDTH-1:0] third_cfg_own,
  input wire logic [THIRD_WIDTH-1:0] third_aout_en,
  input wire logic [THIRD_WIDTH-1:0] third_periph_en,
  input wire logic [THIRD_WIDTH-1:0] third_periph_data,
  output logic [THIRD_WIDTH-1:0] third_din,
  output logic [THIRD_WIDTH-1:0] third_ain_active,
  output logic [THIRD_WIDTH-1:0] third_pullup_en,
  output logic [THIRD_WIDTH-1:0] third_ttl_sel,
  output logic [THIRD_WIDTH-1:0] third_slew_lim
);

  // ********************************************************************
  // port widths as bit masks
  // ********************************************************************
  localparam logic [7:0] PMASK [gpp_pkg::NUM_PORTS] = '{ // RQ12
    8'h3F, (SECOND_PRESENT ? 8'h0F : 8'h00), 8'((1 << THIRD_WIDTH) - 1)};

  logic [7:0] cfg_reg [gpp_pkg::NUM_KINDS][gpp_pkg::NUM_PORTS];
  logic [7:0] lvl_a [gpp_pkg::NUM_PORTS];
  logic [gpp_pkg::FIRST_WIDTH-1:0] lvl0;
  logic [gpp_pkg::SECOND_WIDTH-1:0] lvl1;
  logic [THIRD_WIDTH-1:0] lvl2;
  logic [gpp_pkg::SECOND_WIDTH-1:0] own1;

  // write channel state
  logic aw_got_reg;
  logic w_got_reg;
  logic [gpp_pkg::ADDR_W-1:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic commit;
  logic [6:0] w_dec;
  logic [6:0] r_dec;
  logic [1:0] w_port;
  logic [2:0] w_kind;
  logic [7:0] rmw_mask;
  logic [7:0] rmw_val;
  logic [7:0] read_val;

  // ********************************************************************
  // address decode: {hit, pin-level, kind, port}
  // ********************************************************************
  function automatic logic [6:0] decode(input logic [gpp_pkg::ADDR_W-1:0] a);
    logic [6:0] r;
    r = '0;
    for (int p = 0; p < gpp_pkg::NUM_PORTS; p++) begin
      if (PMASK[p] != 8'h00) begin
        if (a[15:2] == gpp_pkg::PIN_IDX[p]) begin
          r = {1'b1, 1'b1, 3'd0, 2'(p)};
        end
        for (int k = 0; k < gpp_pkg::NUM_KINDS; k++) begin
          if (a[15:2] == gpp_pkg::REG_IDX[k][p]) begin
            r = {1'b1, 1'b0, 3'(k), 2'(p)};
          end
        end
      end
    end
    return r;
  endfunction

  assign w_dec = decode(aw_addr_reg);
  assign r_dec = decode(s_axi_araddr);
  assign w_port = w_dec[1:0];
  assign w_kind = w_dec[4:2];
  assign commit = aw_got_reg && w_got_reg && !s_axi_bvalid;

  assign lvl_a[0] = 8'(lvl0);
  assign lvl_a[1] = 8'(lvl1);
  assign lvl_a[2] = 8'(lvl2);
  // an absent second port is held by the config owner, never driven
  assign own1 = second_cfg_own | {gpp_pkg::SECOND_WIDTH{~SECOND_PRESENT}};

  // ********************************************************************
  // pin-level write: unmodified bits come from the pins, not the latch
  // ********************************************************************
  // byte lane 1, when strobed, selects which bits the write modifies;
  // analog pins sample as zero, so rmw on them clears the latch bit
  assign rmw_mask = w_strb_reg[1] ? w_data_reg[15:8] : gpp_pkg::ALL_BITS;
  assign rmw_val = ((lvl_a[w_port] & ~rmw_mask) | (w_data_reg[7:0] & rmw_mask))
                   & PMASK[w_port]; // RQ4

  // ********************************************************************
  // write address and data channels, taken in either order
  // ********************************************************************
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      aw_got_reg <= 1'b0;
      s_axi_awready <= 1'b1;
      aw_addr_reg <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_got_reg <= 1'b1;
      s_axi_awready <= 1'b0;
      aw_addr_reg <= s_axi_awaddr;
    end else if (commit) begin
      aw_got_reg <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      w_got_reg <= 1'b0;
      s_axi_wready <= 1'b1;
      w_data_reg <= '0;
      w_strb_reg <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_got_reg <= 1'b1;
      s_axi_wready <= 1'b0;
      w_data_reg <= s_axi_wdata;
      w_strb_reg <= s_axi_wstrb;
    end else if (commit) begin
      w_got_reg <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= gpp_pkg::RESP_OKAY;
    end else if (commit) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= w_dec[6] ? gpp_pkg::RESP_OKAY : gpp_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ********************************************************************
  // register array
  // ********************************************************************
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int k = 0; k < gpp_pkg::NUM_KINDS; k++) begin
        for (int p = 0; p < gpp_pkg::NUM_PORTS; p++) begin
          cfg_reg[k][p] <= gpp_pkg::RESET_VAL[k] & PMASK[p]; // RQ14 RQ1
        end
      end
    end else if (commit && w_dec[6] && w_strb_reg[0]) begin
      if (w_dec[5]) begin
        cfg_reg[gpp_pkg::K_LAT][w_port] <= rmw_val; // RQ3 RQ4
      end else begin
        cfg_reg[w_kind][w_port] <= w_data_reg[7:0] & PMASK[w_port]; // RQ3
      end
    end
  end

  // ********************************************************************
  // read channel: answer one cycle after the address is taken
  // ********************************************************************
  // pin-level reads see the pads, latch reads see the stored value
  assign read_val = r_dec[5] ? lvl_a[r_dec[1:0]] : cfg_reg[r_dec[4:2]][r_dec[1:0]]; // RQ2

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= gpp_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= r_dec[6] ? {24'h00_0000, read_val} : 32'h0000_0000;
      s_axi_rresp <= r_dec[6] ? gpp_pkg::RESP_OKAY : gpp_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ********************************************************************
  // the three port instances
  // ********************************************************************
  gpp_pin_cell #(.WIDTH(gpp_pkg::FIRST_WIDTH)) u_first (
    .clock(clock),
    .rst_n(rst_n),
    .latch(cfg_reg[gpp_pkg::K_LAT][0][gpp_pkg::FIRST_WIDTH-1:0]),
    .dir(cfg_reg[gpp_pkg::K_DIR][0][gpp_pkg::FIRST_WIDTH-1:0]),
    .ana_sel(cfg_reg[gpp_pkg::K_ANA][0][gpp_pkg::FIRST_WIDTH-1:0]),
    .od_sel(cfg_reg[gpp_pkg::K_ODS][0][gpp_pkg::FIRST_WIDTH-1:0]),
    .wpu_sel(cfg_reg[gpp_pkg::K_WPU][0][gpp_pkg::FIRST_WIDTH-1:0]),
    .thr_sel(cfg_reg[gpp_pkg::K_THR][0][gpp_pkg::FIRST_WIDTH-1:0]),
    .slw_sel(cfg_reg[gpp_pkg::K_SLW][0][gpp_pkg::FIRST_WIDTH-1:0]),
    .cfg_own(first_cfg_own),
    .aout_en(first_aout_en),
    .periph_en(first_periph_en),
    .periph_data(first_periph_data),
    .pad_in(first_pad_in),
    .pad_out(first_pad_out),
    .pad_oe(first_pad_oe),
    .pin_level(lvl0),
    .din(first_din),
    .ain_active(first_ain_active),
    .pullup_en(first_pullup_en),
    .ttl_sel(first_ttl_sel),
    .slew_lim(first_slew_lim)
  );

  gpp_pin_cell #(.WIDTH(gpp_pkg::SECOND_WIDTH)) u_second (
    .clock(clock),
    .rst_n(rst_n),
    .latch(cfg_reg[gpp_pkg::K_LAT][1][gpp_pkg::SECOND_WIDTH-1:0]),
    .dir(cfg_reg[gpp_pkg::K_DIR][1][gpp_pkg::SECOND_WIDTH-1:0]),
    .ana_sel(cfg_reg[gpp_pkg::K_ANA][1][gpp_pkg::SECOND_WIDTH-1:0]),
    .od_sel(cfg_reg[gpp_pkg::K_ODS][1][gpp_pkg::SECOND_WIDTH-1:0]),
    .wpu_sel(cfg_reg[gpp_pkg::K_WPU][1][gpp_pkg::SECOND_WIDTH-1:0]),
    .thr_sel(cfg_reg[gpp_pkg::K_THR][1][gpp_pkg::SECOND_WIDTH-1:0]),
    .slw_sel(cfg_reg[gpp_pkg::K_SLW][1][gpp_pkg::SECOND_WIDTH-1:0]),
    .cfg_own(own1),
    .aout_en(second_aout_en),
    .periph_en(second_periph_en),
    .periph_data(second_periph_data),
    .pad_in(second_pad_in),
    .pad_out(second_pad_out),
    .pad_oe(second_pad_oe),
    .pin_level(lvl1),
    .din(second_din),
    .ain_active(second_ain_active),
    .pullup_en(second_pullup_en),
    .ttl_sel(second_ttl_sel),
    .slew_lim(second_slew_lim)
  );

  gpp_pin_cell #(.WIDTH(THIRD_WIDTH)) u_third (
    .clock(clock),
    .rst_n(rst_n),
    .latch(cfg_reg[gpp_pkg::K_LAT][2][THIRD_WIDTH-1:0]),
    .dir(cfg_reg[gpp_pkg::K_DIR][2][THIRD_WIDTH-1:0]),
    .ana_sel(cfg_reg[gpp_pkg::K_ANA][2][THIRD_WIDTH-1:0]),
    .od_sel(cfg_reg[gpp_pkg::K_ODS][2][THIRD_WIDTH-1:0]),
    .wpu_sel(cfg_reg[gpp_pkg::K_WPU][2][THIRD_WIDTH-1:0]),
    .thr_sel(cfg_reg[gpp_pkg::K_THR][2][THIRD_WIDTH-1:0]),
    .slw_sel(cfg_reg[gpp_pkg::K_SLW][2][THIRD_WIDTH-1:0]),
    .cfg_own(third_cfg_own),
    .aout_en(third_aout_en),
    .periph_en(third_periph_en),
    .periph_data(third_periph_data),
    .pad_in(third_pad_in),
    .pad_out(third_pad_out),
    .pad_oe(third_pad_oe),
    .pin_level(lvl2),
    .din(third_din),
    .ain_active(third_ain_active),
    .pullup_en(third_pullup_en),
    .ttl_sel(third_ttl_sel),
    .slew_lim(third_slew_lim)
  );

  // ********************************************************************
  // checks
  // ********************************************************************
  logic [7:0] tgt_lat;
  logic [7:0] plain_wr;
  logic [7:0] rd_lvl;
  logic first_cyc_reg;

  assign tgt_lat = cfg_reg[gpp_pkg::K_LAT][w_port];
  assign plain_wr = w_data_reg[7:0] & PMASK[w_port];
  assign rd_lvl = lvl_a[r_dec[1:0]];

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      first_cyc_reg <= 1'b1;
    end else begin
      first_cyc_reg <= 1'b0;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence lat_commit_s;
    commit && w_dec[6] && !w_dec[5] && (w_kind == 3'd0) && w_strb_reg[0];
  endsequence
  sequence pin_commit_s;
    commit && w_dec[6] && w_dec[5] && w_strb_reg[0];
  endsequence
  sequence pin_read_s;
    s_axi_arvalid && s_axi_arready && r_dec[6] && r_dec[5];
  endsequence

  latch_write_a: assert property (lat_commit_s |=> tgt_lat == $past(plain_wr)) // RQ3
    else $error("latch write not stored");
  pin_write_a: assert property (pin_commit_s |=> tgt_lat == $past(rmw_val)) // RQ4
    else $error("pin-level write not merged into latch");
  pin_read_a: assert property (pin_read_s |=> s_axi_rvalid && s_axi_rdata[7:0] == $past(rd_lvl)) // RQ2
    else $error("pin-level read not the pin levels");
  write_resp_a: assert property (commit |=> s_axi_bvalid ##0 !aw_got_reg) // RQ3
    else $error("write response missing");
  reset_ana_a: assert property (first_cyc_reg |->
    cfg_reg[gpp_pkg::K_ANA][0] == PMASK[0] && cfg_reg[gpp_pkg::K_ANA][2] == PMASK[2]) // RQ14
    else $error("analog select not set after reset");

endmodule

// file: gpp_board.sv
// board-side model of the circuitry on one port's pads
module gpp_board #(
  parameter int WIDTH = 8
) (
  // pad side of the block
  input wire logic [WIDTH-1:0] pad_out,
  input wire logic [WIDTH-1:0] pad_oe,
  // external part pulling pads low
  input wire logic [WIDTH-1:0] ext_low,
  output logic [WIDTH-1:0] pad_in
);
  // ****
  // pad level
  // ****
  // released pads rest high on board pull-ups unless ext_low holds them low, never at a stale value
  always_comb pad_in = (pad_oe & pad_out) | (~pad_oe & ~ext_low);
endmodule

// file: tb.sv
// self-checking bench for the general-purpose port block
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // signals
  // ****
  logic clock = 1'b0, rst_n = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [15:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = '0;
  logic [5:0] cfg_a = '0, aout_a = '0, pen_a = '0, pdat_a = '0, xlo_a = '0;
  logic [3:0] cfg_b = '0, aout_b = '0, pen_b = '0, pdat_b = '0, xlo_b = '0;
  logic [7:0] cfg_c = '0, aout_c = '0, pen_c = '0, pdat_c = '0, xlo_c = '0;
  wire awready, wready, bvalid, arready, rvalid;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [5:0] pin_a, out_a, oe_a, din_a, ain_a;
  wire [3:0] pin_b, out_b, oe_b;
  wire [7:0] pin_c, out_c, oe_c;
  int mismatches = 0, n_compared = 0;
  always #50 clock = ~clock;
  gpp_port #(.SECOND_PRESENT(1'b1), .THIRD_WIDTH(8)) gpp_port_inst (
    .clock(clock), .rst_n(rst_n),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .first_pad_in(pin_a), .first_pad_out(out_a), .first_pad_oe(oe_a), .first_cfg_own(cfg_a),
    .first_aout_en(aout_a), .first_periph_en(pen_a), .first_periph_data(pdat_a),
    .first_din(din_a), .first_ain_active(ain_a), .first_pullup_en(), .first_ttl_sel(),
    .first_slew_lim(), .second_pad_in(pin_b), .second_pad_out(out_b), .second_pad_oe(oe_b),
    .second_cfg_own(cfg_b), .second_aout_en(aout_b), .second_periph_en(pen_b),
    .second_periph_data(pdat_b), .second_din(), .second_ain_active(), .second_pullup_en(),
    .second_ttl_sel(), .second_slew_lim(), .third_pad_in(pin_c), .third_pad_out(out_c),
    .third_pad_oe(oe_c), .third_cfg_own(cfg_c), .third_aout_en(aout_c),
    .third_periph_en(pen_c), .third_periph_data(pdat_c), .third_din(), .third_ain_active(),
    .third_pullup_en(), .third_ttl_sel(), .third_slew_lim());
  gpp_board #(.WIDTH(6)) board_a (.pad_out(out_a), .pad_oe(oe_a), .ext_low(xlo_a), .pad_in(pin_a));
  gpp_board #(.WIDTH(4)) board_b (.pad_out(out_b), .pad_oe(oe_b), .ext_low(xlo_b), .pad_in(pin_b));
  gpp_board #(.WIDTH(8)) board_c (.pad_out(out_c), .pad_oe(oe_c), .ext_low(xlo_c), .pad_in(pin_c));
  // ****
  // bus cycles and checks
  // ****
  task automatic report_and_stop();
    if (mismatches == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tmo(input int n);
    chk(32'(n < 40), 32'h1);
    if (n >= 40) report_and_stop();
  endtask
  function automatic logic [13:0] ix(input int k, input int p);
    return gpp_pkg::REG_IDX[k][p];
  endfunction
  task automatic wr(input logic [13:0] i, input logic [15:0] d, input logic [3:0] s = 4'h1,
                    input logic [1:0] r = gpp_pkg::RESP_OKAY);
    int n;
    @(posedge clock);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    awaddr <= {i, 2'b00};
    wdata <= {16'h0000, d};
    wstrb <= s;
    bready <= 1'b1;
    for (n = 0; n < 40 && bvalid !== 1'b1; n++) begin
      @(posedge clock);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    tmo(n);
    chk(32'(bresp), 32'(r));
  endtask
  task automatic rd(input logic [13:0] i, input logic [7:0] e,
                    input logic [1:0] r = gpp_pkg::RESP_OKAY);
    int n;
    @(posedge clock);
    arvalid <= 1'b1;
    araddr <= {i, 2'b00};
    rready <= 1'b1;
    for (n = 0; n < 40 && rvalid !== 1'b1; n++) begin
      @(posedge clock);
      if (arready === 1'b1) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    tmo(n);
    chk(rdata, {24'h00_0000, e});
    chk(32'(rresp), 32'(r));
  endtask
  // pads follow a register change one edge later
  task automatic settle();
    repeat (2) @(posedge clock);
  endtask
  task automatic t_reset();
    rd(ix(gpp_pkg::K_DIR, 0), 8'h3F);
    rd(ix(gpp_pkg::K_ANA, 0), 8'h3F);
    rd(ix(gpp_pkg::K_LAT, 0), 8'h00);
    rd(gpp_pkg::PIN_IDX[0], 8'h00);
    chk(32'(oe_a), 32'h00);
    rd(ix(gpp_pkg::K_DIR, 1), 8'h0F);
    rd(ix(gpp_pkg::K_DIR, 2), 8'hFF);
    rd(14'h0000, 8'h00, gpp_pkg::RESP_SLVERR);
    wr(14'h0000, 16'h00FF, 4'h1, gpp_pkg::RESP_SLVERR);
  endtask
  task automatic t_output();
    wr(ix(gpp_pkg::K_ANA, 0), 16'h0000);
    wr(ix(gpp_pkg::K_DIR, 0), 16'h0038);
    wr(ix(gpp_pkg::K_LAT, 0), 16'h0005);
    xlo_a <= 6'h08;
    settle();
    chk(32'(oe_a), 32'h07);
    chk(32'(out_a & oe_a), 32'h05);
    rd(ix(gpp_pkg::K_LAT, 0), 8'h05);
    rd(gpp_pkg::PIN_IDX[0], 8'h35);
    chk(32'(din_a), 32'h35);
  endtask
  task automatic t_rmw();
    wr(gpp_pkg::PIN_IDX[0], 16'h0100, 4'h3);
    rd(ix(gpp_pkg::K_LAT, 0), 8'h34);
    wr(gpp_pkg::PIN_IDX[0], 16'h0002);
    wr(ix(gpp_pkg::K_LAT, 0), 16'h003F, 4'h2);
    rd(ix(gpp_pkg::K_LAT, 0), 8'h02);
  endtask
  task automatic t_analog();
    wr(ix(gpp_pkg::K_ANA, 0), 16'h003F);
    settle();
    chk(32'(out_a & oe_a), 32'h02);
    chk(32'(din_a), 32'h00);
    chk(32'(ain_a), 32'h3F);
    rd(gpp_pkg::PIN_IDX[0], 8'h00);
    aout_a <= 6'h01;
    cfg_a <= 6'h02;
    settle();
    chk(32'(oe_a), 32'h04);
    chk(32'(ain_a), 32'h3C);
    wr(ix(gpp_pkg::K_ANA, 0), 16'h0000);
    aout_a <= 6'h00;
    cfg_a <= 6'h00;
    settle();
    chk(32'(ain_a), 32'h00);
  endtask
  task automatic t_periph();
    pen_a <= 6'h01;
    pdat_a <= 6'h01;
    wr(ix(gpp_pkg::K_LAT, 0), 16'h0000);
    settle();
    chk(32'(out_a & oe_a), 32'h01);
    rd(gpp_pkg::PIN_IDX[0], 8'h31);
    pen_a <= 6'h00;
  endtask
  task automatic t_drain();
    wr(ix(gpp_pkg::K_ODS, 0), 16'h003F);
    wr(ix(gpp_pkg::K_LAT, 0), 16'h0005);
    settle();
    chk(32'(oe_a), 32'h02);
    chk(32'(out_a & oe_a), 32'h00);
    rd(gpp_pkg::PIN_IDX[0], 8'h35);
  endtask
  task automatic t_third();
    wr(ix(gpp_pkg::K_ANA, 2), 16'h0000);
    wr(ix(gpp_pkg::K_DIR, 2), 16'h0000);
    wr(ix(gpp_pkg::K_LAT, 2), 16'h00A5);
    cfg_c <= 8'hF0;
    xlo_c <= 8'h30;
    settle();
    chk(32'(oe_c), 32'h0F);
    chk(32'(out_c & oe_c), 32'h05);
    rd(gpp_pkg::PIN_IDX[2], 8'hC5);
  endtask
  // latch bit 2 is low, so a high pad there can only come from the peripheral
  task automatic t_second();
    wr(ix(gpp_pkg::K_ANA, 1), 16'h0000);
    wr(ix(gpp_pkg::K_DIR, 1), 16'h0000);
    wr(ix(gpp_pkg::K_LAT, 1), 16'h000A);
    cfg_b <= 4'h1;
    aout_b <= 4'h2;
    pen_b <= 4'h4;
    pdat_b <= 4'h4;
    xlo_b <= 4'h1;
    settle();
    chk(32'(oe_b), 32'h0C);
    chk(32'(out_b & oe_b), 32'h0C);
    rd(gpp_pkg::PIN_IDX[1], 8'h0C);
  endtask
  initial begin
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    t_reset();
    t_output();
    t_rmw();
    t_analog();
    t_periph();
    t_drain();
    t_third();
    t_second();
    report_and_stop();
  end
endmodule
